/* File: hdl/spread_pwm_pkg.sv */
package spread_pwm_pkg;
	localparam int NUM_CH = 10;
	localparam int ALT_CH = 8;
	localparam int CNT_W  = 16;
	// byte offsets of the three bus registers
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] DATA_OFS = 4'h4;
	localparam logic [3:0] SYNC_OFS = 4'h8;
	// control register fields
	localparam int REGSEL_LSB  = 0;
	localparam int CHSEL_LSB   = 4;
	localparam int UPDATE_BIT  = 8;
	localparam int MASTER_BIT  = 12;
	// local register select codes
	localparam logic [1:0] SEL_DUTY = 2'h0;
	localparam logic [1:0] SEL_CFG  = 2'h1;
	// channel config fields
	localparam int CFG_EN_BIT  = 0;
	localparam int CFG_INV_BIT = 1;
	localparam int CFG_ALT_BIT = 2;
	localparam int CFG_SRC_LSB = 3;
	localparam int CFG_PS_LSB  = 6;
	localparam int CFG_RES_LSB = 8;
	// clock source codes, 2 and 3 both external
	localparam logic [1:0] SRC_CORE   = 2'h0;
	localparam logic [1:0] SRC_PERIPH = 2'h1;
	// resolution mapping
	localparam logic [4:0] RES_MIN      = 5'h07;
	localparam logic [3:0] RES_CODE_MAX = 4'h9;
	localparam logic [4:0] SPREAD_BIAS  = 5'h03;
	localparam logic [15:0] LOCAL_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CORE_DIV_DEF   = 2;
	localparam int PERIPH_DIV_DEF = 1;
endpackage : spread_pwm_pkg

/* File: hdl/multi_channel_spread_pwm.sv */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module multi_channel_spread_pwm #(
	parameter int CORE_DIV   = spread_pwm_pkg::CORE_DIV_DEF,
	parameter int PERIPH_DIV = spread_pwm_pkg::PERIPH_DIV_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        extClkPin,
	output logic [9:0]       pwmPin,
	output logic [7:0]       pwmAltPin
);
	localparam int N = spread_pwm_pkg::NUM_CH;

	function automatic logic [15:0] mergeBytes(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		mergeBytes = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : mergeBytes

	function automatic logic [3:0] resCode(input logic [15:0] cfg);
		logic [3:0] c;
		c = cfg[spread_pwm_pkg::CFG_RES_LSB +: 4];
		resCode = (c > spread_pwm_pkg::RES_CODE_MAX) ? spread_pwm_pkg::RES_CODE_MAX : c;
	endfunction : resCode

	function automatic logic [15:0] resMask(input logic [15:0] cfg);
		logic [4:0] nb;
		nb = spread_pwm_pkg::RES_MIN + {1'b0, resCode(cfg)};
		resMask = 16'(17'((17'h1 << nb) - 17'h1));
	endfunction : resMask

	function automatic logic [3:0] spreadShift(input logic [15:0] cfg);
		logic [4:0] t;
		t = {1'b0, resCode(cfg)} + {3'b0, cfg[spread_pwm_pkg::CFG_PS_LSB +: 2]};
		spreadShift = (t > spread_pwm_pkg::SPREAD_BIAS) ?
			4'(t - spread_pwm_pkg::SPREAD_BIAS) : 4'h0;
	endfunction : spreadShift

	// bus registers
	logic        awHave, wHave, bvalidReg, rvalidReg;
	logic [3:0]  awAddr;
	logic [15:0] wData;
	logic [1:0]  wStrb, bresp, rresp;
	logic [31:0] rdataReg;
	logic [1:0]  regSel;
	logic [3:0]  chanSel;
	logic        updateReg, masterEn;
	logic [9:0]  syncReg;
	logic [15:0] dutyLocal [N];
	logic [15:0] cfgLocal  [N];
	logic [15:0] delayLocal[N];

	logic doWrite, doRead, wrCtrl, wrData, wrSync, rdData, chanValid;
	assign s_axi_awready = !awHave;
	assign s_axi_wready  = !wHave;
	assign doWrite       = awHave && wHave && !bvalidReg;
	assign s_axi_arready = !rvalidReg && !doWrite;
	assign doRead        = s_axi_arvalid && s_axi_arready;
	assign wrCtrl        = doWrite && awAddr == spread_pwm_pkg::CTRL_OFS;
	assign wrData        = doWrite && awAddr == spread_pwm_pkg::DATA_OFS;
	assign wrSync        = doWrite && awAddr == spread_pwm_pkg::SYNC_OFS;
	assign rdData        = doRead && s_axi_araddr == spread_pwm_pkg::DATA_OFS;
	assign chanValid     = 32'(chanSel) < N;
	assign s_axi_bvalid  = bvalidReg;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalidReg;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = rdataReg;

	function automatic logic isMapped(input logic [3:0] a);
		isMapped = a == spread_pwm_pkg::CTRL_OFS || a == spread_pwm_pkg::DATA_OFS ||
			a == spread_pwm_pkg::SYNC_OFS;
	endfunction : isMapped

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			awHave    <= 1'b0;
			wHave     <= 1'b0;
			awAddr    <= 4'h0;
			wData     <= 16'h0000;
			wStrb     <= 2'h0;
			bvalidReg <= 1'b0;
			bresp     <= spread_pwm_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHave) begin
				awHave <= 1'b1;
				awAddr <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (s_axi_wvalid && !wHave) begin
				wHave <= 1'b1;
				wData <= s_axi_wdata[15:0];
				wStrb <= s_axi_wstrb[1:0];
			end
			if (doWrite) begin
				awHave    <= 1'b0;
				wHave     <= 1'b0;
				bvalidReg <= 1'b1;
				bresp     <= isMapped(awAddr) ? spread_pwm_pkg::RESP_OKAY :
					spread_pwm_pkg::RESP_SLVERR;
			end else if (bvalidReg && s_axi_bready) begin
				bvalidReg <= 1'b0;
			end
		end
	end

	logic [15:0] localRead;
	always_comb begin
		localRead = 16'h0000;
		if (chanValid) begin
			unique case (regSel)
				spread_pwm_pkg::SEL_DUTY: localRead = dutyLocal[chanSel];
				spread_pwm_pkg::SEL_CFG:  localRead = cfgLocal[chanSel];
				default:                  localRead = delayLocal[chanSel];
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rvalidReg <= 1'b0;
			rdataReg  <= 32'h00000000;
			rresp     <= spread_pwm_pkg::RESP_OKAY;
		end else if (doRead) begin
			rvalidReg <= 1'b1;
			rresp     <= isMapped({s_axi_araddr[3:2], 2'h0}) ? spread_pwm_pkg::RESP_OKAY :
				spread_pwm_pkg::RESP_SLVERR;
			unique case ({s_axi_araddr[3:2], 2'h0})
				spread_pwm_pkg::CTRL_OFS: rdataReg <= {19'h0, masterEn, 3'h0, updateReg,
					chanSel, 2'h0, regSel};
				spread_pwm_pkg::DATA_OFS: rdataReg <= {16'h0000, localRead};
				spread_pwm_pkg::SYNC_OFS: rdataReg <= {22'h0, syncReg};
				default:                  rdataReg <= 32'h00000000;
			endcase
		end else if (rvalidReg && s_axi_rready) begin
			rvalidReg <= 1'b0;
		end
	end

	// control register with pointer advance
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			regSel    <= 2'h0;
			chanSel   <= 4'h0;
			updateReg <= 1'b0;
			masterEn  <= 1'b0;
		end else begin
			updateReg <= 1'b0;
			if (wrCtrl && wStrb[0]) begin
				regSel  <= wData[spread_pwm_pkg::REGSEL_LSB +: 2];
				chanSel <= wData[spread_pwm_pkg::CHSEL_LSB +: 4];
			end else if (wrData || rdData) begin
				chanSel <= chanSel + 4'h1;
			end
			if (wrCtrl && wStrb[1]) begin
				updateReg <= wData[spread_pwm_pkg::UPDATE_BIT];
				masterEn  <= wData[spread_pwm_pkg::MASTER_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			syncReg <= 10'h000;
		end else begin
			syncReg <= wrSync ? 10'(mergeBytes(16'h0000, wData, wStrb)) : 10'h000;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N; i++) begin
				dutyLocal[i]  <= spread_pwm_pkg::LOCAL_RST;
				cfgLocal[i]   <= spread_pwm_pkg::LOCAL_RST;
				delayLocal[i] <= spread_pwm_pkg::LOCAL_RST;
			end
		end else if (wrData && chanValid) begin
			unique case (regSel)
				spread_pwm_pkg::SEL_DUTY:
					dutyLocal[chanSel] <= mergeBytes(dutyLocal[chanSel], wData, wStrb);
				spread_pwm_pkg::SEL_CFG:
					cfgLocal[chanSel] <= mergeBytes(cfgLocal[chanSel], wData, wStrb);
				default:
					delayLocal[chanSel] <= mergeBytes(delayLocal[chanSel], wData, wStrb);
			endcase
		end
	end

	// count enables: core and peripheral dividers, external pin edge
	logic [7:0] coreCnt, periCnt;
	logic       extMeta, extSync, extLast, tickCore, tickPeri, tickExt;
	assign tickCore = coreCnt == 8'h00;
	assign tickPeri = periCnt == 8'h00;
	assign tickExt  = extSync && !extLast;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			coreCnt <= 8'h00;
			periCnt <= 8'h00;
		end else begin
			coreCnt <= (32'(coreCnt) >= CORE_DIV - 1) ? 8'h00 : coreCnt + 8'h01;
			periCnt <= (32'(periCnt) >= PERIPH_DIV - 1) ? 8'h00 : periCnt + 8'h01;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			extMeta <= 1'b0;
			extSync <= 1'b0;
			extLast <= 1'b0;
		end else begin
			extMeta <= extClkPin;
			extSync <= extMeta;
			extLast <= extSync;
		end
	end

	// channel engines
	logic [15:0] cnt       [N];
	logic [15:0] delayCnt  [N];
	logic [15:0] dutyActive[N];
	logic [9:0]  acc       [N];
	logic [N-1:0] running, extra, pending, chTick, chOn, outReg;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			unique case (cfgLocal[i][spread_pwm_pkg::CFG_SRC_LSB +: 2])
				spread_pwm_pkg::SRC_CORE:   chTick[i] = tickCore;
				spread_pwm_pkg::SRC_PERIPH: chTick[i] = tickPeri;
				default:                    chTick[i] = tickExt;
			endcase
			chOn[i] = masterEn && cfgLocal[i][spread_pwm_pkg::CFG_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < N; i++) begin
				cnt[i]        <= 16'h0000;
				delayCnt[i]   <= 16'h0000;
				dutyActive[i] <= 16'h0000;
				acc[i]        <= 10'h000;
			end
			running <= '0;
			extra   <= '0;
			pending <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				logic [15:0] m, d, nxt;
				logic [3:0]  k;
				logic [9:0]  rem, slots, sum;
				logic        start;
				m     = resMask(cfgLocal[i]);
				k     = spreadShift(cfgLocal[i]);
				slots = 10'(11'h1 << k);
				start = 1'b0;
				nxt   = 16'h0000;
				if (updateReg) pending[i] <= 1'b1;
				if (!chOn[i] || syncReg[i]) begin
					running[i]  <= 1'b0;
					cnt[i]      <= 16'h0000;
					delayCnt[i] <= delayLocal[i] & (m >> k);
					acc[i]      <= 10'h000;
					extra[i]    <= 1'b0;
					if (!chOn[i] && (pending[i] || updateReg)) begin
						dutyActive[i] <= dutyLocal[i];
						pending[i]    <= 1'b0;
					end
				end else if (chTick[i]) begin
					if (!running[i]) begin
						if (delayCnt[i] == 16'h0000) begin
							running[i] <= 1'b1;
							start      = 1'b1;
						end else begin
							delayCnt[i] <= delayCnt[i] - 16'h0001;
						end
					end else begin
						nxt    = (cnt[i] == m) ? 16'h0000 : cnt[i] + 16'h0001;
						start  = nxt == 16'h0000;
						cnt[i] <= nxt;
					end
					d = dutyActive[i];
					if (start && pending[i]) begin
						d             = dutyLocal[i];
						dutyActive[i] <= dutyLocal[i];
						pending[i]    <= 1'b0;
					end
					d   = d & m;
					rem = 10'(d & 16'(17'((17'h1 << k) - 17'h1)));
					sum = (start ? 10'h000 : acc[i]) + rem;
					if ((nxt & (m >> k)) == 16'h0000) begin
						extra[i] <= sum >= slots;
						acc[i]   <= (sum >= slots) ? sum - slots : sum;
					end
				end
			end
		end
	end

	// registered pin drive
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			outReg <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				logic [15:0] m, inSlot;
				logic [16:0] q;
				logic [3:0]  k;
				m      = resMask(cfgLocal[i]);
				k      = spreadShift(cfgLocal[i]);
				inSlot = cnt[i] & (m >> k);
				q      = {1'b0, (dutyActive[i] & m) >> k} + {16'h0000, extra[i]};
				if (!chOn[i] || !running[i]) begin
					outReg[i] <= 1'b0;
				end else begin
					outReg[i] <= ({1'b0, inSlot} < q) ^
						cfgLocal[i][spread_pwm_pkg::CFG_INV_BIT];
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (i < spread_pwm_pkg::ALT_CH) begin
				pwmAltPin[i] = outReg[i] && cfgLocal[i][spread_pwm_pkg::CFG_ALT_BIT];
				pwmPin[i]    = outReg[i] && !cfgLocal[i][spread_pwm_pkg::CFG_ALT_BIT];
			end else begin
				pwmPin[i] = outReg[i];
			end
		end
	end
endmodule : multi_channel_spread_pwm

/* File: tb/spread_pwm_props.sv */
`timescale 1ns/1ps
module spread_pwm_props (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [9:0]  pwmPin,
	input wire logic [7:0]  pwmAltPin
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic       wrFire;
	logic [3:0] rdAddr_reg;
	logic       masterOn_reg;
	logic [2:0] offCnt_reg;
	assign wrFire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) rdAddr_reg <= 4'h0;
		else if (s_axi_arvalid && s_axi_arready) rdAddr_reg <= s_axi_araddr;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) masterOn_reg <= 1'h0;
		else if (wrFire && s_axi_awaddr == spread_pwm_pkg::CTRL_OFS)
			masterOn_reg <= s_axi_wdata[spread_pwm_pkg::MASTER_BIT];
	end
	// cycles since master enable went off, saturating
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) offCnt_reg <= 3'h0;
		else if (masterOn_reg) offCnt_reg <= 3'h0;
		else if (offCnt_reg != 3'h7) offCnt_reg <= offCnt_reg + 3'h1;
	end
	chk_master_gate: assert property (offCnt_reg == 3'h7 |-> pwmPin == 10'h0 && pwmAltPin == 8'h0)
		else $error("pin active while master enable is off");
	chk_alt_excl: assert property ((pwmPin[7:0] & pwmAltPin) == 8'h0)
		else $error("default and alternate pin both high");
	chk_wr_answer: assert property (wrFire |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rd_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (rdAddr_reg[3:2] == 2'h3 ?
		spread_pwm_pkg::RESP_SLVERR : spread_pwm_pkg::RESP_OKAY)) else $error("read response code wrong");
	chk_sync_zero: assert property (s_axi_rvalid && rdAddr_reg == spread_pwm_pkg::SYNC_OFS |-> s_axi_rdata == 32'h0)
		else $error("sync register did not clear");
	cover property (wrFire && s_axi_awaddr == spread_pwm_pkg::SYNC_OFS);
	cover property ($rose(pwmAltPin[1]));
	cover property ($rose(pwmPin[0]));
endmodule : spread_pwm_props
bind multi_channel_spread_pwm spread_pwm_props chk_u (
	.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .pwmPin, .pwmAltPin);

/* File: tb/pwm_load_model.sv */
`timescale 1ns/1ps
module pwm_load_model (
	input wire logic        clk_sys,
	input wire logic [9:0]  pwmPin,
	input wire logic [7:0]  pwmAltPin,
	input wire logic [4:0]  selPin,
	output logic            extClkPin,
	output logic [15:0]     hiLen,
	output logic [15:0]     perLen,
	output logic [15:0]     hiSum8
);
	logic [17:0]      pins;
	logic             prev = 1'h0;
	logic [15:0]      hiCnt = 16'h0;
	logic [15:0]      perCnt = 16'h0;
	logic [7:0][15:0] hist = '0;
	assign pins = {pwmAltPin, pwmPin};
	assign hiSum8 = hist[0] + hist[1] + hist[2] + hist[3] + hist[4] + hist[5] + hist[6] + hist[7];
	// count clock of five system clocks, edges kept off the system clock edges
	initial begin
		extClkPin = 1'h0;
		#7;
		forever #100 extClkPin = ~extClkPin;
	end
	// last high width, rise-to-rise period and last eight widths of the watched pin
	always @(posedge clk_sys) begin
		prev <= pins[selPin];
		perCnt <= (pins[selPin] && !prev) ? 16'h1 : perCnt + 16'h1;
		if (pins[selPin] && !prev) perLen <= perCnt;
		hiCnt <= pins[selPin] ? hiCnt + 16'h1 : 16'h0;
		if (!pins[selPin] && prev) begin
			hiLen <= hiCnt;
			hist <= {hiCnt, hist[7:1]};
		end
	end
endmodule : pwm_load_model

/* File: tb/multi_channel_spread_pwm_tb.sv */
`timescale 1ns/1ps
module multi_channel_spread_pwm_tb;
	typedef struct packed {logic wr; logic [3:0] a; logic [15:0] d; logic [1:0] rsp;} row_s;
	localparam logic [3:0] CTL = spread_pwm_pkg::CTRL_OFS;
	localparam logic [3:0] DAT = spread_pwm_pkg::DATA_OFS;
	localparam logic [3:0] SYN = spread_pwm_pkg::SYNC_OFS;
	localparam logic [1:0] OK = spread_pwm_pkg::RESP_OKAY;
	logic        clk_sys = 1'h0, reset_n = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [9:0]  pwmPin;
	logic [7:0]  pwmAltPin;
	logic        extClkPin;
	logic [4:0]  selPin = 5'h0;
	logic [15:0] hiLen, perLen, hiSum8;
	int          error_cnt = 0, n_tests = 0;
	row_s        rows [22] = '{
		'{1'h1, CTL, 16'h0000, OK}, '{1'h1, DAT, 16'h3fc0, OK}, '{1'h1, DAT, 16'h0011, OK},
		'{1'h0, CTL, 16'h0020, OK}, '{1'h1, CTL, 16'h0090, OK}, '{1'h1, DAT, 16'h1234, OK},
		'{1'h0, DAT, 16'h0000, OK}, '{1'h0, CTL, 16'h00b0, OK}, '{1'h1, CTL, 16'h0003, OK},
		'{1'h1, DAT, 16'h0005, OK}, '{1'h1, CTL, 16'h0002, OK}, '{1'h0, DAT, 16'h0005, OK},
		'{1'h1, CTL, 16'h0000, OK}, '{1'h0, DAT, 16'h3fc0, OK}, '{1'h0, DAT, 16'h0011, OK},
		'{1'h1, CTL, 16'h0001, OK}, '{1'h1, DAT, 16'h0001, OK}, '{1'h1, DAT, 16'h0007, OK},
		'{1'h0, CTL, 16'h0021, OK}, '{1'h1, 4'hc, 16'h0, spread_pwm_pkg::RESP_SLVERR},
		'{1'h0, 4'hc, 16'h0, spread_pwm_pkg::RESP_SLVERR}, '{1'h0, SYN, 16'h0000, OK}};
	multi_channel_spread_pwm #(.CORE_DIV(1), .PERIPH_DIV(2)) dut_u (
		.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extClkPin, .pwmPin, .pwmAltPin);
	pwm_load_model load_u (.clk_sys, .pwmPin, .pwmAltPin, .selPin, .extClkPin, .hiLen,
		.perLen, .hiSum8);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic check(input logic [31:0] got, input logic [31:0] expv);
		n_tests++;
		if (got !== expv) begin
			error_cnt++;
			$display("MISMATCH %0t got %h want %h", $time, got, expv);
		end
	endtask : check
	task automatic access(input row_s rw);
		int   t;
		logic aw, w, ar;
		t = 0;
		aw = !rw.wr;
		w = !rw.wr;
		ar = rw.wr;
		s_axi_awaddr <= rw.a;
		s_axi_araddr <= rw.a;
		s_axi_wdata <= {16'h0, rw.d};
		s_axi_awvalid <= rw.wr;
		s_axi_wvalid <= rw.wr;
		s_axi_bready <= rw.wr;
		s_axi_arvalid <= !rw.wr;
		s_axi_rready <= !rw.wr;
		do begin
			@(posedge clk_sys);
			t++;
			aw = aw || s_axi_awready;
			w = w || s_axi_wready;
			ar = ar || s_axi_arready;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!(aw && w && ar && (s_axi_bvalid || s_axi_rvalid)) && t < 200);
		if (t >= 200) begin
			error_cnt++;
			$display("MISMATCH %0t bus answer timed out", $time);
		end
		if (!rw.wr) check(s_axi_rdata, {16'h0, rw.d});
		check({30'h0, rw.wr ? s_axi_bresp : s_axi_rresp}, {30'h0, rw.rsp});
	endtask : access
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (15000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		foreach (rows[i]) access(rows[i]);
		access('{1'h1, CTL, 16'h1100, OK});
		repeat (400) @(posedge clk_sys);
		check({hiLen, perLen}, 32'h0040_0080);
		selPin <= 5'h0b;
		repeat (300) @(posedge clk_sys);
		check({hiLen, perLen}, 32'h006f_0080);
		check({30'h0, pwmPin[2:1]}, 32'h0);
		selPin <= 5'h00;
		access('{1'h1, CTL, 16'h1000, OK});
		access('{1'h1, DAT, 16'h0020, OK});
		repeat (300) @(posedge clk_sys);
		check({16'h0, hiLen}, 32'h0040);
		access('{1'h1, CTL, 16'h1100, OK});
		repeat (300) @(posedge clk_sys);
		check({16'h0, hiLen}, 32'h0020);
		// both channels share resolution, spreading and core source
		access('{1'h1, SYN, 16'h0003, OK});
		access('{1'h0, SYN, 16'h0000, OK});
		repeat (300) @(posedge clk_sys);
		check({hiLen, perLen}, 32'h0020_0080);
		access('{1'h1, CTL, 16'h1001, OK});
		access('{1'h1, DAT, 16'h03c1, OK});
		access('{1'h1, CTL, 16'h1000, OK});
		access('{1'h1, DAT, 16'h0081, OK});
		access('{1'h1, CTL, 16'h1100, OK});
		repeat (3000) @(posedge clk_sys);
		check({hiSum8, perLen}, 32'h0081_0080);
		// ext and periph channels loaded while off, so the update applies at once
		access('{1'h1, CTL, 16'h1021, OK});
		access('{1'h1, DAT, 16'h0010, OK});
		access('{1'h1, DAT, 16'h0fc8, OK});
		access('{1'h1, CTL, 16'h1020, OK});
		access('{1'h1, DAT, 16'h0040, OK});
		access('{1'h1, DAT, 16'h2000, OK});
		access('{1'h1, CTL, 16'h1121, OK});
		access('{1'h1, DAT, 16'h0011, OK});
		access('{1'h1, DAT, 16'h0fc9, OK});
		selPin <= 5'h02;
		repeat (1500) @(posedge clk_sys);
		check({hiLen, perLen}, 32'h0140_0280);
		selPin <= 5'h03;
		repeat (700) @(posedge clk_sys);
		check({hiLen, perLen}, 32'h0020_0100);
		access('{1'h1, CTL, 16'h0000, OK});
		repeat (4) @(posedge clk_sys);
		check({14'h0, pwmAltPin, pwmPin}, 32'h0);
		access('{1'h1, CTL, 16'h1000, OK});
		repeat (20) @(posedge clk_sys);
		check({31'h0, pwmPin[2]}, 32'h1);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		check({14'h0, pwmAltPin, pwmPin}, 32'h0);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		access('{1'h0, CTL, 16'h0000, OK});
		print_verdict();
	end
endmodule : multi_channel_spread_pwm_tb
